// file: fsp_pkg.sv
`default_nettype none
package fsp_pkg;
  localparam int ADDR_W = 15;
  localparam int DATA_W = 14;
  localparam int AXI_AW = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_UNLK = 8'h04;
  localparam logic [7:0] OFS_DLO = 8'h08;
  localparam logic [7:0] OFS_DHI = 8'h0C;
  localparam logic [7:0] OFS_ALO = 8'h10;
  localparam logic [7:0] OFS_AHI = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  localparam logic [7:0] OFS_MASK = 8'h1C;
  localparam logic [7:0] OFS_CFG = 8'h20;
  // Control register bits
  localparam int CB_RD = 0;
  localparam int CB_WR = 1;
  localparam int CB_WRITE_ALLOW = 2;
  localparam int CB_WERR = 3;
  localparam int CB_FREE = 4;
  localparam int CB_LWLO = 5;
  // Interrupt status bits
  localparam int IRQ_W = 3;
  localparam int IB_DONE = 0;
  localparam int IB_REFUSE = 1;
  localparam int IB_FAULT = 2;
  localparam logic [7:0] UNLOCK_1 = 8'h55;
  localparam logic [7:0] UNLOCK_2 = 8'hAA;
  localparam logic [1:0] UL_NONE = 2'h0;
  localparam logic [1:0] UL_HALF = 2'h1;
  localparam logic [1:0] UL_ARMED = 2'h2;
  localparam logic [1:0] WP_ALL = 2'h0;
  localparam logic [1:0] WP_HALF = 2'h1;
  localparam logic [1:0] WP_QUARTER = 2'h2;
  localparam logic [1:0] WP_NONE = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int CLK_MHZ = 100;
  localparam int WRITE_TIME_US = 2000;
  localparam int OP_CYCLES_DEF = WRITE_TIME_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_LATCH = 4'h4,
    ST_TIMED = 4'h8
  } fsp_state_t;
endpackage
`default_nettype wire

// file: fsp_op_timer.sv
`default_nettype none
module fsp_op_timer #(
  parameter int CYCLES = fsp_pkg::OP_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LOAD = CW'(CYCLES - 1);
  logic [CW-1:0] cnt_reg;

  // Counts clock cycles only, so software loops play no part in timing
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= '0;
      busy <= 1'b0;
    end else if (start) begin
      cnt_reg <= LOAD;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_reg == '0) begin
        busy <= 1'b0;
      end else begin
        cnt_reg <= cnt_reg - CW'(1);
      end
    end
  end

  assign done = busy && (cnt_reg == '0);
endmodule
`default_nettype wire

// file: fsp_ctrl.sv
// Local design decisions: register access over AXI4-Lite and the register offsets.
`default_nettype none
module fsp_ctrl #(
  parameter int MEM_WORDS = 1024,
  parameter int OP_CYCLES = fsp_pkg::OP_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic por_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic code_protect_n,
  input wire logic [1:0] write_protect_range,
  input wire logic ext_mode,
  input wire logic ext_read_req,
  input wire logic ext_write_req,
  input wire logic ext_bulk_erase,
  output logic ext_read_ok,
  output logic ext_write_ok,
  output logic flash_bulk_erase,
  output logic [14:0] flash_addr,
  output logic [13:0] flash_wdata,
  output logic flash_read,
  input wire logic [13:0] flash_rdata,
  output logic flash_latch_load,
  output logic flash_erase,
  output logic flash_program,
  output logic cpu_stall,
  output logic irq
);
  localparam logic [14:0] QTR_LIM = 15'(MEM_WORDS / 4);
  localparam logic [14:0] HALF_LIM = 15'(MEM_WORDS / 2);

  logic aw_hold_reg, w_hold_reg, w_lane_reg;
  logic [7:0] aw_addr_reg, w_data_reg;
  logic [1:0] bresp_reg;
  logic wr_fire, wr_en, ctrl_wr, unlk_wr, rd_fire, rd_hit;
  logic [31:0] rd_mux;
  fsp_pkg::fsp_state_t state_reg;
  logic rd_bit_reg, wr_bit_reg, write_allow_reg, free_reg, lwlo_reg, werr_reg;
  logic [7:0] dlo_reg, alo_reg;
  logic [5:0] dhi_reg;
  logic [6:0] ahi_reg;
  logic [1:0] unlock_reg;
  localparam int IRQ_W_L = fsp_pkg::IRQ_W;
  logic [IRQ_W_L-1:0] stat_reg, mask_reg, ev;
  logic rd_go, wr_go, prot_hit, refuse, start_ok, op_latch, op_timed;
  logic op_end, tmr_done, persist_reg, fault_set, cp_active_reg;
  logic [1:0] init_reg;
  logic [3:0] sy1_reg, sy2_reg, sy3_reg;
  logic [14:0] word_addr;

  // Write channel: address and data captured in either order
  assign s_axi_awready = !aw_hold_reg && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_reg && !s_axi_bvalid;
  assign wr_fire = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
  assign wr_en = wr_fire && w_lane_reg && rd_hit_w(aw_addr_reg);
  assign ctrl_wr = wr_en && (aw_addr_reg == fsp_pkg::OFS_CTRL);
  assign unlk_wr = wr_en && (aw_addr_reg == fsp_pkg::OFS_UNLK);
  assign s_axi_bresp = bresp_reg;

  function automatic logic rd_hit_w(input logic [7:0] a);
    rd_hit_w = (a <= fsp_pkg::OFS_CFG) && (a[1:0] == 2'h0);
  endfunction

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      bresp_reg <= fsp_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end else if (wr_fire) begin
        w_hold_reg <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        bresp_reg <= rd_hit_w(aw_addr_reg) ? fsp_pkg::RESP_OKAY
                                           : fsp_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read channel
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign word_addr = {ahi_reg, alo_reg};

  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      fsp_pkg::OFS_CTRL: begin
        rd_mux[fsp_pkg::CB_RD] = rd_bit_reg;
        rd_mux[fsp_pkg::CB_WR] = wr_bit_reg;
        rd_mux[fsp_pkg::CB_WRITE_ALLOW] = write_allow_reg;
        rd_mux[fsp_pkg::CB_WERR] = werr_reg;
        rd_mux[fsp_pkg::CB_FREE] = free_reg;
        rd_mux[fsp_pkg::CB_LWLO] = lwlo_reg;
      end
      fsp_pkg::OFS_UNLK: rd_mux = 32'h0000_0000;
      fsp_pkg::OFS_DLO: rd_mux[7:0] = dlo_reg;
      fsp_pkg::OFS_DHI: rd_mux[5:0] = dhi_reg;
      fsp_pkg::OFS_ALO: rd_mux[7:0] = alo_reg;
      fsp_pkg::OFS_AHI: rd_mux[6:0] = ahi_reg;
      fsp_pkg::OFS_STAT: rd_mux[IRQ_W_L-1:0] = stat_reg;
      fsp_pkg::OFS_MASK: rd_mux[IRQ_W_L-1:0] = mask_reg;
      fsp_pkg::OFS_CFG: rd_mux[3:0] = {write_protect_range,
                                       code_protect_n, cp_active_reg};
      default: rd_hit = 1'b0;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= fsp_pkg::RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? fsp_pkg::RESP_OKAY : fsp_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Self-write region check; external side never sees it
  always_comb begin
    case (write_protect_range)
      fsp_pkg::WP_NONE: prot_hit = 1'b0;
      fsp_pkg::WP_QUARTER: prot_hit = word_addr < QTR_LIM;
      fsp_pkg::WP_HALF: prot_hit = word_addr < HALF_LIM;
      default: prot_hit = 1'b1;
    endcase
  end

  // A trigger write with both bits set is treated as a read only
  assign rd_go = ctrl_wr && w_data_reg[fsp_pkg::CB_RD]
                 && (state_reg == fsp_pkg::ST_IDLE);
  assign wr_go = ctrl_wr && w_data_reg[fsp_pkg::CB_WR]
                 && !w_data_reg[fsp_pkg::CB_RD]
                 && (state_reg == fsp_pkg::ST_IDLE)
                 && (unlock_reg == fsp_pkg::UL_ARMED)
                 && w_data_reg[fsp_pkg::CB_WRITE_ALLOW];
  assign refuse = wr_go && prot_hit;
  assign start_ok = wr_go && !prot_hit;
  assign op_latch = start_ok && w_data_reg[fsp_pkg::CB_LWLO]
                    && !w_data_reg[fsp_pkg::CB_FREE];
  assign op_timed = start_ok && !op_latch;
  assign op_end = (state_reg == fsp_pkg::ST_LATCH)
                  || ((state_reg == fsp_pkg::ST_TIMED) && tmr_done);

  // Any other register write breaks the unlock pattern
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      unlock_reg <= fsp_pkg::UL_NONE;
    end else if (unlk_wr) begin
      if (w_data_reg == fsp_pkg::UNLOCK_1) begin
        unlock_reg <= fsp_pkg::UL_HALF;
      end else if (w_data_reg == fsp_pkg::UNLOCK_2
                   && unlock_reg == fsp_pkg::UL_HALF) begin
        unlock_reg <= fsp_pkg::UL_ARMED;
      end else begin
        unlock_reg <= fsp_pkg::UL_NONE;
      end
    end else if (wr_en) begin
      unlock_reg <= fsp_pkg::UL_NONE;
    end
  end

  fsp_op_timer #(
    .CYCLES(OP_CYCLES)
  ) u_timer (
    .clk(clk),
    .resetn(resetn),
    .start(op_timed),
    .busy(),
    .done(tmr_done)
  );

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= fsp_pkg::ST_IDLE;
      rd_bit_reg <= 1'b0;
      wr_bit_reg <= 1'b0;
      write_allow_reg <= 1'b0;
      free_reg <= 1'b0;
      lwlo_reg <= 1'b0;
      flash_read <= 1'b0;
      flash_latch_load <= 1'b0;
      dlo_reg <= 8'h00;
      dhi_reg <= 6'h00;
      alo_reg <= 8'h00;
      ahi_reg <= 7'h00;
    end else begin
      flash_read <= rd_go;
      flash_latch_load <= start_ok;
      if (ctrl_wr) begin
        write_allow_reg <= w_data_reg[fsp_pkg::CB_WRITE_ALLOW];
        if (state_reg == fsp_pkg::ST_IDLE) begin
          free_reg <= w_data_reg[fsp_pkg::CB_FREE];
          lwlo_reg <= w_data_reg[fsp_pkg::CB_LWLO];
        end
      end
      if (wr_en && aw_addr_reg == fsp_pkg::OFS_ALO) alo_reg <= w_data_reg;
      if (wr_en && aw_addr_reg == fsp_pkg::OFS_AHI) begin
        ahi_reg <= w_data_reg[6:0];
      end
      if (wr_en && aw_addr_reg == fsp_pkg::OFS_DLO) dlo_reg <= w_data_reg;
      if (wr_en && aw_addr_reg == fsp_pkg::OFS_DHI) begin
        dhi_reg <= w_data_reg[5:0];
      end
      case (state_reg)
        fsp_pkg::ST_IDLE: begin
          if (rd_go) begin
            rd_bit_reg <= 1'b1;
            state_reg <= fsp_pkg::ST_READ;
          end else if (op_latch) begin
            wr_bit_reg <= 1'b1;
            state_reg <= fsp_pkg::ST_LATCH;
          end else if (op_timed) begin
            wr_bit_reg <= 1'b1;
            state_reg <= fsp_pkg::ST_TIMED;
          end
        end
        fsp_pkg::ST_READ: begin
          {dhi_reg, dlo_reg} <= flash_rdata;
          rd_bit_reg <= 1'b0;
          state_reg <= fsp_pkg::ST_IDLE;
        end
        fsp_pkg::ST_LATCH: begin
          wr_bit_reg <= 1'b0;
          state_reg <= fsp_pkg::ST_IDLE;
        end
        fsp_pkg::ST_TIMED: begin
          if (tmr_done) begin
            wr_bit_reg <= 1'b0;
            state_reg <= fsp_pkg::ST_IDLE;
          end
        end
        default: state_reg <= fsp_pkg::ST_IDLE;
      endcase
    end
  end

  assign flash_addr = word_addr;
  assign flash_wdata = {dhi_reg, dlo_reg};
  assign flash_erase = (state_reg == fsp_pkg::ST_TIMED) && free_reg;
  assign flash_program = (state_reg == fsp_pkg::ST_TIMED) && !free_reg;
  assign cpu_stall = (state_reg == fsp_pkg::ST_TIMED);

  // Survives ordinary resets so an interrupted write is seen afterwards
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      init_reg <= 2'h0;
    end else begin
      init_reg <= {init_reg[0], 1'b1};
    end
  end
  assign fault_set = init_reg[0] && !init_reg[1] && persist_reg;

  always_ff @(posedge clk or negedge por_n) begin
    if (!por_n) begin
      persist_reg <= 1'b0;
      werr_reg <= 1'b0;
    end else begin
      if (op_timed) begin
        persist_reg <= 1'b1;
      end else if (op_end || fault_set) begin
        persist_reg <= 1'b0;
      end
      // Set wins over a software clear in the same cycle
      werr_reg <= fault_set
                  || (werr_reg && !(ctrl_wr && !w_data_reg[fsp_pkg::CB_WERR]));
    end
  end

  // Interrupt status, cleared by reading it
  always_comb begin
    ev = '0;
    ev[fsp_pkg::IB_DONE] = op_end || (state_reg == fsp_pkg::ST_READ);
    ev[fsp_pkg::IB_REFUSE] = refuse;
    ev[fsp_pkg::IB_FAULT] = fault_set;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      stat_reg <= '0;
      mask_reg <= '0;
    end else begin
      if (rd_fire && s_axi_araddr == fsp_pkg::OFS_STAT) begin
        stat_reg <= ev;
      end else begin
        stat_reg <= stat_reg | ev;
      end
      if (wr_en && aw_addr_reg == fsp_pkg::OFS_MASK) begin
        mask_reg <= w_data_reg[IRQ_W_L-1:0];
      end
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // External programmer pins: {bulk, write, read, mode}
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sy1_reg <= 4'h0;
      sy2_reg <= 4'h0;
      sy3_reg <= 4'h0;
      cp_active_reg <= 1'b1;
      ext_read_ok <= 1'b0;
      ext_write_ok <= 1'b0;
      flash_bulk_erase <= 1'b0;
    end else begin
      sy1_reg <= {ext_bulk_erase, ext_write_req, ext_read_req, ext_mode};
      sy2_reg <= sy1_reg;
      sy3_reg <= sy2_reg;
      if (sy2_reg[0] && sy2_reg[3] && !sy3_reg[3]) begin
        cp_active_reg <= 1'b0;
      end else if (init_reg[0] && !init_reg[1]) begin
        cp_active_reg <= !code_protect_n;
      end
      ext_read_ok <= sy2_reg[0] && sy2_reg[1] && !cp_active_reg;
      ext_write_ok <= sy2_reg[0] && sy2_reg[2] && !cp_active_reg;
      flash_bulk_erase <= sy2_reg[0] && sy2_reg[3];
    end
  end

  rd_clear_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg == fsp_pkg::ST_READ |=> !rd_bit_reg)
    else $error("read trigger not cleared after read");
  wr_fall_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(wr_bit_reg) |-> $past(op_end))
    else $error("write trigger cleared before completion");
  unlock_zero_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_fire && s_axi_araddr == fsp_pkg::OFS_UNLK |=> s_axi_rdata == 0)
    else $error("unlock register read not zero");
  unlock_need_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(wr_bit_reg) |-> $past(unlock_reg) == fsp_pkg::UL_ARMED)
    else $error("write started without unlock");
  stall_timed_a: assert property (@(posedge clk) disable iff (!resetn)
    op_timed |=> cpu_stall throughout (!tmr_done [*2]))
    else $error("processor not stalled during timed operation");
  prot_refuse_a: assert property (@(posedge clk) disable iff (!resetn)
    refuse |=> !wr_bit_reg && state_reg == fsp_pkg::ST_IDLE)
    else $error("protected write not refused");
  cp_ext_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(cp_active_reg) |-> !ext_read_ok && !ext_write_ok)
    else $error("external access granted under code protection");
  fault_set_a: assert property (@(posedge clk) disable iff (!por_n)
    fault_set |=> werr_reg)
    else $error("fault flag not set after interrupted write");
  data_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    state_reg != fsp_pkg::ST_READ
    && !(wr_en && aw_addr_reg == fsp_pkg::OFS_DLO) |=> $stable(dlo_reg))
    else $error("data low changed without read or write");
endmodule
`default_nettype wire

// file: fsp_flash_model.sv
`default_nettype none
module fsp_flash_model #(
  parameter int WORDS = 1024
) (
  input wire logic clk,
  input wire logic [14:0] addr,
  input wire logic [13:0] wdata,
  input wire logic rd,
  input wire logic load,
  output logic [13:0] rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [13:0] mem [WORDS];
  logic rd_q = 1'b0;
  logic [13:0] word;
  initial begin
    for (int i = 0; i < WORDS; i++) mem[i] = 14'(i * 37) ^ 14'h1555;
  end
  assign word = mem[int'(addr) % WORDS];
  // Outside the read slot the bus shows the inverse, so stale data fails
  assign rdata = (rd || rd_q) ? word : ~word;
  always @(posedge clk) begin
    rd_q <= rd;
    if (load) mem[int'(addr) % WORDS] <= wdata;
  end
endmodule
`default_nettype wire

// file: fsp_ctrl_tb.sv
`default_nettype none
module fsp_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int OPC = 20;
  logic clk = 0, resetn = 0, por_n = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rs, wpr = 2'h3;
  logic cpn = 1, emode = 0, erd = 0, ewr = 0, ebulk = 0;
  logic erd_ok, ewr_ok, fbulk, frd, fload, ferase, fprog, stall, irq;
  logic [14:0] faddr;
  logic [13:0] fwd, frdata;
  int error_cnt = 0, tests_run = 0, loads = 0, stalls = 0;

  always #5 clk = ~clk;
  // Counted mid-cycle so the edge's own updates have landed
  always @(negedge clk) begin
    if (fload) loads++;
    if (stall) stalls++;
  end

  fsp_ctrl #(.MEM_WORDS(1024), .OP_CYCLES(OPC)) dut (
    .clk(clk), .resetn(resetn), .por_n(por_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .code_protect_n(cpn),
    .write_protect_range(wpr), .ext_mode(emode), .ext_read_req(erd),
    .ext_write_req(ewr), .ext_bulk_erase(ebulk), .ext_read_ok(erd_ok),
    .ext_write_ok(ewr_ok), .flash_bulk_erase(fbulk), .flash_addr(faddr),
    .flash_wdata(fwd), .flash_read(frd), .flash_rdata(frdata),
    .flash_latch_load(fload), .flash_erase(ferase),
    .flash_program(fprog), .cpu_stall(stall), .irq(irq)
  );

  fsp_flash_model #(.WORDS(1024)) flash (
    .clk(clk), .addr(faddr), .wdata(fwd), .rd(frd), .load(fload),
    .rdata(frdata)
  );

  task automatic chk(input string what, input logic [31:0] got, exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic close_out();
    $display("checks %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ap, dp, ah, dh;
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    ap = 1;
    dp = 1;
    n = 0;
    while ((ap || dp) && n < 50) begin
      @(negedge clk);
      ah = ap && awready;
      dh = dp && wready;
      @(posedge clk);
      if (ah) awvalid <= 0;
      if (dh) wvalid <= 0;
      ap = ap && !ah;
      dp = dp && !dh;
      n++;
    end
    do begin
      @(negedge clk);
      ah = bvalid;
      @(posedge clk);
      n++;
    end while (!ah && n < 100);
    bready <= 0;
    if (n >= 100) chk("write answer", 1, 0);
  endtask

  task automatic rd(input logic [7:0] a);
    logic h;
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    n = 0;
    do begin
      @(negedge clk);
      h = arready;
      @(posedge clk);
      n++;
    end while (!h && n < 50);
    arvalid <= 0;
    do begin
      @(negedge clk);
      h = rvalid;
      rv = rdata;
      rs = rresp;
      @(posedge clk);
      n++;
    end while (!h && n < 100);
    rready <= 0;
    if (n >= 100) chk("read answer", 1, 0);
  endtask

  task automatic do_reset(input logic por);
    @(posedge clk);
    resetn <= 0;
    if (por) por_n <= 0;
    repeat (8) @(posedge clk);
    resetn <= 1;
    por_n <= 1;
    repeat (2) @(posedge clk);
  endtask

  task automatic unlock();
    wr(fsp_pkg::OFS_UNLK, 32'h00000055);
    wr(fsp_pkg::OFS_UNLK, 32'h000000AA);
  endtask

  task automatic setaddr(input logic [14:0] a);
    wr(fsp_pkg::OFS_ALO, {24'h0, a[7:0]});
    wr(fsp_pkg::OFS_AHI, {25'h0, a[14:8]});
  endtask

  task automatic t_regs();
    rd(fsp_pkg::OFS_CTRL);
    chk("allow at power-up", rv[fsp_pkg::CB_WRITE_ALLOW], 0);
    wr(fsp_pkg::OFS_UNLK, 32'h00000055);
    rd(fsp_pkg::OFS_UNLK);
    chk("unlock readback", rv, 0);
    rd(8'h24);
    chk("unmapped resp", rs, fsp_pkg::RESP_SLVERR);
    wr(8'h24, 32'h00000007);
    chk("unmapped wresp", bresp, fsp_pkg::RESP_SLVERR);
    // Byte lane 0 off: the write is answered but changes nothing
    wstrb <= 4'h0;
    wr(fsp_pkg::OFS_MASK, 32'h00000007);
    wstrb <= 4'hF;
    rd(fsp_pkg::OFS_MASK);
    chk("lane off mask", rv, 0);
  endtask

  task automatic t_read();
    logic [13:0] e;
    logic [7:0] lo;
    e = 14'(801 * 37) ^ 14'h1555;
    setaddr(15'h4321);
    chk("addr pair", faddr, 15'h4321);
    wr(fsp_pkg::OFS_CTRL, 32'h00000001);
    rd(fsp_pkg::OFS_CTRL);
    chk("read trigger", rv[fsp_pkg::CB_RD], 0);
    chk("masked irq", irq, 0);
    setaddr(15'h0002);
    rd(fsp_pkg::OFS_DLO);
    lo = rv[7:0];
    rd(fsp_pkg::OFS_DHI);
    chk("read word", {rv[5:0], lo}, e);
    chk("data pair out", fwd, e);
  endtask

  task automatic t_bad();
    int l0;
    l0 = loads;
    wr(fsp_pkg::OFS_CTRL, 32'h00000026);
    wr(fsp_pkg::OFS_UNLK, 32'h000000AA);
    wr(fsp_pkg::OFS_UNLK, 32'h00000055);
    wr(fsp_pkg::OFS_CTRL, 32'h00000026);
    wr(fsp_pkg::OFS_UNLK, 32'h00000055);
    wr(fsp_pkg::OFS_DLO, 32'h00000011);
    wr(fsp_pkg::OFS_UNLK, 32'h000000AA);
    wr(fsp_pkg::OFS_CTRL, 32'h00000026);
    unlock();
    wr(fsp_pkg::OFS_CTRL, 32'h00000022);
    chk("blocked loads", loads - l0, 0);
    rd(fsp_pkg::OFS_CTRL);
    chk("trigger idle", rv[fsp_pkg::CB_WR], 0);
  endtask

  task automatic t_prot();
    logic [1:0] r [6] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [14:0] a [6] = '{15'h300, 15'h1FF, 15'h200, 15'h0FF, 15'h100,
      15'h000};
    logic ok [6] = '{0, 0, 1, 0, 1, 1};
    int l0;
    for (int i = 0; i < 6; i++) begin
      wpr <= r[i];
      setaddr(a[i]);
      l0 = loads;
      unlock();
      wr(fsp_pkg::OFS_CTRL, 32'h00000026);
      rd(fsp_pkg::OFS_STAT);
      chk("load accepted", loads - l0, ok[i]);
      chk("refused flag", rv[fsp_pkg::IB_REFUSE], !ok[i]);
    end
  endtask

  task automatic t_timed(input logic [31:0] c);
    int s0, n;
    wr(fsp_pkg::OFS_MASK, 32'h00000001);
    setaddr(15'h0240);
    unlock();
    s0 = stalls;
    wr(fsp_pkg::OFS_CTRL, c);
    @(negedge clk);
    chk("stall up", stall, 1);
    chk("erase level", ferase, c[4]);
    chk("program level", fprog, !c[4]);
    // Clearing the trigger by software must not cut the operation short
    wr(fsp_pkg::OFS_CTRL, 32'h00000004);
    rd(fsp_pkg::OFS_CTRL);
    chk("trigger held", rv[fsp_pkg::CB_WR], 1);
    n = 0;
    while (stall && n < 1000) begin
      @(negedge clk);
      n++;
    end
    chk("stall span", stalls - s0, OPC);
    rd(fsp_pkg::OFS_CTRL);
    chk("trigger cleared", rv[fsp_pkg::CB_WR], 0);
    chk("irq raised", irq, 1);
    rd(fsp_pkg::OFS_STAT);
    chk("done status", rv[fsp_pkg::IB_DONE], 1);
    chk("irq cleared", irq, 0);
  endtask

  task automatic t_ext();
    int l0;
    wpr <= fsp_pkg::WP_ALL;
    emode <= 1;
    erd <= 1;
    ewr <= 1;
    repeat (6) @(negedge clk);
    chk("ext read open", erd_ok, 1);
    chk("ext write open", ewr_ok, 1);
    @(posedge clk);
    cpn <= 0;
    wpr <= fsp_pkg::WP_NONE;
    do_reset(1);
    repeat (6) @(negedge clk);
    chk("ext read locked", erd_ok, 0);
    chk("ext write locked", ewr_ok, 0);
    l0 = loads;
    setaddr(15'h0300);
    unlock();
    wr(fsp_pkg::OFS_CTRL, 32'h00000026);
    chk("self write", loads - l0, 1);
    ebulk <= 1;
    repeat (6) @(negedge clk);
    chk("bulk erase", fbulk, 1);
    chk("ext read reopened", erd_ok, 1);
    @(posedge clk);
    ebulk <= 0;
    emode <= 0;
    cpn <= 1;
  endtask

  task automatic t_fault();
    setaddr(15'h0280);
    unlock();
    wr(fsp_pkg::OFS_CTRL, 32'h00000016);
    do_reset(0);
    rd(fsp_pkg::OFS_CTRL);
    chk("fault flag", rv[fsp_pkg::CB_WERR], 1);
    wr(fsp_pkg::OFS_CTRL, 32'h00000000);
    rd(fsp_pkg::OFS_CTRL);
    chk("fault cleared", rv[fsp_pkg::CB_WERR], 0);
  endtask

  // Whole run is near five hundred cycles; forty times that means a hang
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end

  initial begin
    do_reset(1);
    t_regs();
    t_read();
    t_bad();
    t_prot();
    t_timed(32'h00000016);
    t_timed(32'h00000006);
    t_ext();
    t_fault();
    close_out();
  end
endmodule
`default_nettype wire
